// ==== rtl/mms_pkg.sv ====
// Constants and types for the program memory map and stack unit
package mms_pkg;
	typedef enum logic [3:0] {
		OP_FETCH, OP_JUMP, OP_LDC, OP_LOAD_PROGRAM_AUTOINC, OP_LDE, OP_LOAD_DATA_AUTOINC,
		OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_INT, OP_INTERRUPT_RETURN
	} mms_op_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_STEP, ST_INT1, ST_INT2, ST_WAIT_EXT
	} mms_state_t;
	typedef enum logic [1:0] {BP_IDLE, BP_ADDR, BP_DATA, BP_LAST} mms_bph_t;

	localparam int VEC_ENTRIES = 6;
	localparam logic [15:0] VEC_BYTES = 16'h000c;
	localparam logic [15:0] ROM_TOP_DEF = 16'h0fff;
	localparam logic [15:0] EXT_DATA_BASE = 16'h1000;
	localparam logic [15:0] PC_RST = 16'h000c;
	localparam logic [7:0] REG_PORT01_MODE_REG = 8'hf8;
	localparam logic [7:0] REG_SPH = 8'hfe;
	localparam logic [7:0] REG_SPL = 8'hff;
	localparam logic [7:0] PORT01_MODE_REG_RST = 8'h04;
	localparam int PORT01_MODE_REG_STK_BIT = 2;
	localparam logic [7:0] SP_RST = 8'h00;
	localparam logic [7:0] GP_LIMIT = 8'hf0;
	localparam logic [7:0] NOP_OPCODE = 8'hff;
	localparam logic [1:0] DM_EN_BITS = 2'h3;
endpackage : mms_pkg

// ==== rtl/mms_ext_bus.sv ====
// External memory bus cycle engine on ports 0 and 1
module mms_ext_bus (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic go,
	input wire logic wr,
	input wire logic dm,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] mux_in,
	output logic [7:0] addr_high_byte,
	output logic [7:0] mux_out,
	output logic mux_oe,
	output logic address_strobe_n,
	output logic data_strobe_n,
	output logic read_write_n,
	output logic dm_n,
	output logic done,
	output logic [7:0] rdata
);
	mms_pkg::mms_bph_t ph_q;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ph_q <= mms_pkg::BP_IDLE;
			addr_high_byte <= 8'h00;
			mux_out <= 8'h00;
			mux_oe <= 1'b0;
			address_strobe_n <= 1'b1;
			data_strobe_n <= 1'b1;
			read_write_n <= 1'b1;
			dm_n <= 1'b1;
			done <= 1'b0;
			rdata <= 8'h00;
		end else begin
			done <= 1'b0;
			case (ph_q)
				mms_pkg::BP_IDLE: if (go) begin
					// Address phase: low byte shares port 1 with data
					addr_high_byte <= addr[15:8];
					mux_out <= addr[7:0];
					mux_oe <= 1'b1;
					address_strobe_n <= 1'b0;
					read_write_n <= ~wr;
					dm_n <= ~dm;
					ph_q <= mms_pkg::BP_ADDR;
				end
				mms_pkg::BP_ADDR: begin
					address_strobe_n <= 1'b1;
					data_strobe_n <= 1'b0;
					mux_out <= wdata;
					mux_oe <= wr;
					ph_q <= mms_pkg::BP_DATA;
				end
				mms_pkg::BP_DATA: ph_q <= mms_pkg::BP_LAST;
				default: begin
					data_strobe_n <= 1'b1;
					rdata <= mux_in;
					done <= 1'b1;
					mux_oe <= 1'b0;
					read_write_n <= 1'b1;
					dm_n <= 1'b1;
					ph_q <= mms_pkg::BP_IDLE;
				end
			endcase
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_strobe_order: assert property (
		$fell(address_strobe_n) |=> $rose(address_strobe_n)
		&& $fell(data_strobe_n) ##2 $rose(data_strobe_n))
		else $error("strobe sequence wrong");
	a_addr_on_ports: assert property (
		(ph_q == mms_pkg::BP_IDLE && go) |=> (mux_oe
		&& mux_out == $past(addr[7:0])
		&& addr_high_byte == $past(addr[15:8])))
		else $error("address not driven on ports");
endmodule : mms_ext_bus

// ==== rtl/mms_core.sv ====
// Program memory map, external fetch, ROM protect and stack unit
module mms_core #(
	parameter logic [15:0] ROM_TOP = mms_pkg::ROM_TOP_DEF,
	parameter bit HAS_EXT_PORTS = 1'b1,
	parameter bit ROM_PROTECT = 1'b0
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic cmd_valid,
	input wire mms_pkg::mms_op_t cmd_op,
	input wire logic [15:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_blocked,
	output logic [15:0] rsp_ptr,
	output logic [15:0] pc_value,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] port3_mode_dm,
	output logic rom_rd,
	output logic [15:0] rom_addr,
	input wire logic [7:0] rom_data,
	output logic rf_re,
	output logic rf_we,
	output logic [7:0] rf_addr,
	output logic [7:0] rf_wdata,
	input wire logic [7:0] rf_rdata,
	output logic [7:0] addr_high_byte,
	output logic [7:0] mux_addr_data_low_out,
	output logic mux_addr_data_low_oe,
	input wire logic [7:0] mux_addr_data_low_in,
	output logic address_strobe_n,
	output logic data_strobe_n,
	output logic read_write_n,
	output logic port3_bit4
);
	mms_pkg::mms_state_t state_q;
	mms_pkg::mms_op_t op_q;
	logic [15:0] pc_q, addr_q;
	logic [7:0] wdata_q, port01_mode_reg_q, sph_q, spl_q, pch_tmp_q, flags_tmp_q;
	logic [1:0] cnt_q, total_q;
	logic rom_sel_q, rf_ok_q, ext_go_q, ext_wr_q, ext_dm_q;
	logic [15:0] ext_addr_q;
	logic [7:0] ext_wdata_q;
	logic bus_done;
	logic [7:0] bus_rdata;

	// Operation classes
	wire logic is_push = op_q inside {mms_pkg::OP_PUSH, mms_pkg::OP_CALL,
		mms_pkg::OP_INT};
	wire logic is_pop = op_q inside {mms_pkg::OP_POP, mms_pkg::OP_RET,
		mms_pkg::OP_INTERRUPT_RETURN};
	wire logic is_stk = is_push | is_pop;
	wire logic is_ldc = op_q inside {mms_pkg::OP_LDC, mms_pkg::OP_LOAD_PROGRAM_AUTOINC};
	wire logic is_lde = op_q inside {mms_pkg::OP_LDE, mms_pkg::OP_LOAD_DATA_AUTOINC};
	wire logic is_ld = is_ldc | is_lde;
	wire logic is_inc = op_q inside {mms_pkg::OP_LOAD_PROGRAM_AUTOINC, mms_pkg::OP_LOAD_DATA_AUTOINC};
	wire logic is_fetch = op_q == mms_pkg::OP_FETCH;
	wire logic [1:0] idx = total_q - cnt_q;

	// Stack placement and pointer arithmetic
	wire logic stk_int = port01_mode_reg_q[mms_pkg::PORT01_MODE_REG_STK_BIT];
	wire logic [15:0] sp16 = {sph_q, spl_q};
	wire logic [7:0] spl_dec = spl_q - 8'h01;
	wire logic [7:0] spl_inc = spl_q + 8'h01;
	wire logic [15:0] sp_dec = stk_int ? {sph_q, spl_dec}
		: sp16 - 16'h0001;
	wire logic [15:0] sp_inc = stk_int ? {sph_q, spl_inc}
		: sp16 + 16'h0001;

	// Target selection for the current byte
	wire logic beyond = pc_q > ROM_TOP;
	wire logic ld_prog = is_ldc | (is_lde
		&& addr_q < mms_pkg::EXT_DATA_BASE);
	wire logic blk = ROM_PROTECT && is_ld && ld_prog;
	wire logic [15:0] acc_addr = is_push ? sp_dec
		: is_pop ? sp16 : is_fetch ? pc_q : addr_q;
	wire logic use_rom = (is_fetch && !beyond)
		|| (is_ld && ld_prog && addr_q <= ROM_TOP && !blk);
	wire logic use_rf = is_stk && stk_int;
	wire logic rf_ok = acc_addr[7:0] < mms_pkg::GP_LIMIT;
	wire logic no_ext = (is_fetch || is_ld) && !use_rom && !HAS_EXT_PORTS;
	wire logic local_done = op_q == mms_pkg::OP_JUMP || blk || no_ext;
	wire logic use_ext = !local_done && !use_rom && !use_rf;
	wire logic dm_en = port3_mode_dm == mms_pkg::DM_EN_BITS;
	wire logic dm_act = is_lde || (is_stk && !stk_int);
	wire logic [7:0] local_val = (is_fetch && no_ext) ? mms_pkg::NOP_OPCODE
		: 8'h00;

	// Byte pushed for each step of a multi-byte save
	wire logic [7:0] push_byte = op_q == mms_pkg::OP_PUSH ? wdata_q
		: idx == 2'd0 ? pc_q[7:0]
		: idx == 2'd1 ? pc_q[15:8] : wdata_q;

	wire logic step_fin = state_q == mms_pkg::ST_STEP && local_done;
	wire logic byte_done = step_fin || state_q == mms_pkg::ST_INT2
		|| (state_q == mms_pkg::ST_WAIT_EXT && bus_done);
	wire logic [7:0] byte_val = state_q == mms_pkg::ST_INT2
		? (rom_sel_q ? rom_data : rf_ok_q ? rf_rdata : 8'h00)
		: state_q == mms_pkg::ST_WAIT_EXT ? bus_rdata : local_val;
	wire logic last = cnt_q == 2'd1;
	wire logic take = cmd_valid && cmd_ready;
	wire logic [1:0] cmd_total = cmd_op inside {mms_pkg::OP_CALL,
		mms_pkg::OP_RET} ? 2'd2 : cmd_op inside {mms_pkg::OP_INT,
		mms_pkg::OP_INTERRUPT_RETURN} ? 2'd3 : 2'd1;
	wire logic [7:0] reg_rd_mux = reg_addr == mms_pkg::REG_PORT01_MODE_REG ? port01_mode_reg_q
		: reg_addr == mms_pkg::REG_SPH ? sph_q
		: reg_addr == mms_pkg::REG_SPL ? spl_q : 8'h00;

	// Sequencer
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q <= mms_pkg::ST_IDLE;
			op_q <= mms_pkg::OP_FETCH;
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			cnt_q <= 2'd0;
			total_q <= 2'd0;
			cmd_ready <= 1'b0;
		end else begin
			case (state_q)
				mms_pkg::ST_IDLE: begin
					cmd_ready <= 1'b1;
					if (take) begin
						op_q <= cmd_op;
						addr_q <= cmd_addr;
						wdata_q <= cmd_wdata;
						cnt_q <= cmd_total;
						total_q <= cmd_total;
						cmd_ready <= 1'b0;
						state_q <= mms_pkg::ST_STEP;
					end
				end
				mms_pkg::ST_STEP: begin
					if (local_done) state_q <= mms_pkg::ST_IDLE;
					else if (use_ext) state_q <= mms_pkg::ST_WAIT_EXT;
					else state_q <= mms_pkg::ST_INT1;
				end
				mms_pkg::ST_INT1: state_q <= mms_pkg::ST_INT2;
				default: begin
					if (byte_done) begin
						cnt_q <= cnt_q - 2'd1;
						state_q <= last ? mms_pkg::ST_IDLE : mms_pkg::ST_STEP;
					end
				end
			endcase
		end
	end

	// Memory strobes for the current byte
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rom_rd <= 1'b0;
			rom_addr <= 16'h0000;
			rf_re <= 1'b0;
			rf_we <= 1'b0;
			rf_addr <= 8'h00;
			rf_wdata <= 8'h00;
			rom_sel_q <= 1'b0;
			rf_ok_q <= 1'b0;
			ext_go_q <= 1'b0;
			ext_wr_q <= 1'b0;
			ext_dm_q <= 1'b0;
			ext_addr_q <= 16'h0000;
			ext_wdata_q <= 8'h00;
		end else begin
			rom_rd <= 1'b0;
			rf_re <= 1'b0;
			rf_we <= 1'b0;
			ext_go_q <= 1'b0;
			if (state_q == mms_pkg::ST_STEP && !local_done) begin
				rom_sel_q <= use_rom;
				rf_ok_q <= rf_ok;
				if (use_rom) begin
					rom_rd <= 1'b1;
					rom_addr <= acc_addr;
				end else if (use_rf) begin
					rf_addr <= acc_addr[7:0];
					rf_wdata <= push_byte;
					rf_we <= is_push && rf_ok;
					rf_re <= is_pop && rf_ok;
				end else begin
					ext_go_q <= 1'b1;
					ext_wr_q <= is_push;
					ext_dm_q <= dm_act && dm_en;
					ext_addr_q <= acc_addr;
					ext_wdata_q <= push_byte;
				end
			end
		end
	end

	// Program counter, stack pointer and mode registers
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pc_q <= mms_pkg::PC_RST;
			port01_mode_reg_q <= mms_pkg::PORT01_MODE_REG_RST;
			sph_q <= mms_pkg::SP_RST;
			spl_q <= mms_pkg::SP_RST;
			pch_tmp_q <= 8'h00;
			flags_tmp_q <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == mms_pkg::REG_PORT01_MODE_REG) port01_mode_reg_q <= reg_wdata;
			if (reg_wr && reg_addr == mms_pkg::REG_SPH) sph_q <= reg_wdata;
			if (reg_wr && reg_addr == mms_pkg::REG_SPL) spl_q <= reg_wdata;
			if (state_q == mms_pkg::ST_STEP && is_stk) begin
				{sph_q, spl_q} <= is_push ? sp_dec : sp_inc;
			end
			if (byte_done) begin
				if ((op_q == mms_pkg::OP_INTERRUPT_RETURN) && idx == 2'd0)
					flags_tmp_q <= byte_val;
				if ((op_q == mms_pkg::OP_RET && idx == 2'd0)
					|| (op_q == mms_pkg::OP_INTERRUPT_RETURN && idx == 2'd1))
					pch_tmp_q <= byte_val;
				if (last) begin
					case (op_q)
						mms_pkg::OP_FETCH: pc_q <= pc_q + 16'h0001;
						mms_pkg::OP_JUMP, mms_pkg::OP_CALL,
						mms_pkg::OP_INT: pc_q <= addr_q;
						mms_pkg::OP_RET,
						mms_pkg::OP_INTERRUPT_RETURN: pc_q <= {pch_tmp_q, byte_val};
						default: pc_q <= pc_q;
					endcase
				end
			end
		end
	end

	// Answer to the core
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_blocked <= 1'b0;
			rsp_ptr <= 16'h0000;
			reg_rdata <= 8'h00;
			pc_value <= mms_pkg::PC_RST;
		end else begin
			reg_rdata <= reg_rd_mux;
			pc_value <= pc_q;
			rsp_valid <= byte_done && last;
			if (byte_done && last) begin
				rsp_data <= op_q == mms_pkg::OP_INTERRUPT_RETURN ? flags_tmp_q : byte_val;
				rsp_blocked <= blk;
				rsp_ptr <= (is_inc && !blk) ? addr_q + 16'h0001 : addr_q;
			end
		end
	end

	mms_ext_bus u_bus (
		.core_clk(core_clk),
		.nrst(nrst),
		.go(ext_go_q),
		.wr(ext_wr_q),
		.dm(ext_dm_q),
		.addr(ext_addr_q),
		.wdata(ext_wdata_q),
		.mux_in(mux_addr_data_low_in),
		.addr_high_byte(addr_high_byte),
		.mux_out(mux_addr_data_low_out),
		.mux_oe(mux_addr_data_low_oe),
		.address_strobe_n(address_strobe_n),
		.data_strobe_n(data_strobe_n),
		.read_write_n(read_write_n),
		.dm_n(port3_bit4),
		.done(bus_done),
		.rdata(bus_rdata)
	);

	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_rom_inside: assert property (
		(state_q == mms_pkg::ST_STEP && is_fetch && !beyond)
		|=> rom_rd && rom_addr == $past(pc_q))
		else $error("internal fetch not from ROM");
	a_ext_fetch: assert property (
		(state_q == mms_pkg::ST_STEP && is_fetch && beyond && HAS_EXT_PORTS)
		|=> ext_go_q ##1 !address_strobe_n)
		else $error("external fetch not started");
	a_nop_wrap: assert property (
		(byte_done && is_fetch && pc_q == 16'hffff) |=> pc_q == 16'h0000)
		else $error("program counter did not wrap");
	a_prot_noread: assert property (
		(state_q == mms_pkg::ST_STEP && blk)
		|=> !rom_rd && !ext_go_q && rsp_valid && rsp_blocked)
		else $error("protected load performed a read");
	a_blk_ptr: assert property (
		(rsp_valid && rsp_blocked) |-> rsp_ptr == addr_q)
		else $error("blocked load moved pointer");
	a_push_predec: assert property (
		(state_q == mms_pkg::ST_STEP && is_push && !stk_int)
		|=> sp16 == $past(sp16) - 16'h0001)
		else $error("push did not predecrement");
	a_int_high: assert property (
		(state_q == mms_pkg::ST_STEP && is_stk && stk_int && !reg_wr)
		|=> sph_q == $past(sph_q))
		else $error("internal stack touched high byte");
	a_stack_gp: assert property (
		(rf_we || rf_re) |-> rf_addr < mms_pkg::GP_LIMIT)
		else $error("internal stack left general registers");
	a_call_pc: assert property (
		(byte_done && last && op_q == mms_pkg::OP_CALL) |=> pc_q == addr_q)
		else $error("call did not load target");
	a_dm_select: assert property (
		(ext_go_q && is_lde && dm_en) |=> !port3_bit4)
		else $error("data select not active for data load");

	c_ext_fetch: cover property (ext_go_q && is_fetch);
	c_vector: cover property (rom_rd && rom_addr < mms_pkg::VEC_BYTES);
	c_blocked: cover property (rsp_valid && rsp_blocked);
	c_interrupt_return: cover property (rsp_valid && op_q == mms_pkg::OP_INTERRUPT_RETURN);
endmodule : mms_core

// ==== testbench/mms_mem_model.sv ====
// Program ROM, register file and external memory seen by the core
module mms_mem_model (
	input wire logic core_clk,
	input wire logic rom_rd,
	input wire logic [15:0] rom_addr,
	output logic [7:0] rom_data,
	input wire logic rf_re,
	input wire logic rf_we,
	input wire logic [7:0] rf_addr,
	input wire logic [7:0] rf_wdata,
	output logic [7:0] rf_rdata,
	input wire logic [7:0] addr_high_byte,
	input wire logic [7:0] mux_out,
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_write_n,
	output logic [7:0] mux_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ext [65536];
	logic [7:0] rf [256];
	logic [15:0] lat_q;
	logic tog_q = 1'b0;
	initial begin
		for (int i = 0; i < 65536; i++) begin
			ext[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
		end
		for (int i = 0; i < 256; i++) begin
			rf[i] = 8'h00;
		end
		rom_data = 8'h00;
		rf_rdata = 8'h00;
	end
	// Released bus shows a pattern that changes every cycle
	assign mux_in = (!data_strobe_n && read_write_n) ? ext[lat_q] :
		{4{tog_q, ~tog_q}};
	always @(posedge core_clk) begin
		tog_q <= ~tog_q;
		if (!address_strobe_n) begin
			lat_q <= {addr_high_byte, mux_out};
		end
		if (!data_strobe_n && !read_write_n) begin
			ext[lat_q] <= mux_out;
		end
		rom_data <= rom_rd ? (rom_addr[7:0] ^ 8'ha5) : ~rom_data;
		if (rf_we) begin
			rf[rf_addr] <= rf_wdata;
		end
		rf_rdata <= rf_re ? rf[rf_addr] : ~rf_rdata;
	end
endmodule : mms_mem_model

// ==== testbench/test_memory_map_and_stack.sv ====
// Self-checking bench for the memory map and stack unit
module test_memory_map_and_stack;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, nrst, cmd_valid, reg_wr, cmd_ready, rsp_valid;
	logic rsp_blocked, rom_rd, rf_re, rf_we, mux_oe, seen_dm, port3_bit4;
	logic address_strobe_n, data_strobe_n, read_write_n;
	mms_pkg::mms_op_t cmd_op;
	logic [15:0] cmd_addr, rsp_ptr, pc_value, rom_addr, seen_addr, sp, mpc;
	logic [7:0] cmd_wdata, rsp_data, reg_addr, reg_wdata, reg_rdata;
	logic [7:0] rom_data, rf_addr, rf_wdata, rf_rdata, addr_high_byte;
	logic [7:0] mux_out, mux_in, flags;
	logic [1:0] port3_mode_dm;
	logic seen_oe, p_valid, p_ready, p_rsp_valid, p_blocked;
	logic p_rom_rd, p_rf_re, p_rf_we, p_as, p_ds, p_rw;
	logic [15:0] p_ptr, p_pc, p_rom_addr;
	logic [7:0] p_rsp_data, p_rom_data, p_rf_addr, p_rf_wdata, p_rf_rdata;
	logic [7:0] p_ahb, p_mux_out, p_mux_in;
	logic [31:0] seed = 32'h633381b9;
	logic [7:0] stk [$];
	int fail_count, check_count;
	mms_pkg::mms_op_t lops [4] = '{mms_pkg::OP_LDC, mms_pkg::OP_LOAD_PROGRAM_AUTOINC,
		mms_pkg::OP_LDE, mms_pkg::OP_LOAD_DATA_AUTOINC};

	mms_core dut (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_blocked(rsp_blocked), .rsp_ptr(rsp_ptr), .pc_value(pc_value),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .port3_mode_dm(port3_mode_dm),
		.rom_rd(rom_rd), .rom_addr(rom_addr), .rom_data(rom_data),
		.rf_re(rf_re), .rf_we(rf_we), .rf_addr(rf_addr),
		.rf_wdata(rf_wdata), .rf_rdata(rf_rdata),
		.addr_high_byte(addr_high_byte), .mux_addr_data_low_out(mux_out),
		.mux_addr_data_low_oe(mux_oe), .mux_addr_data_low_in(mux_in),
		.address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
		.read_write_n(read_write_n), .port3_bit4(port3_bit4));

	mms_mem_model mem (.core_clk(core_clk), .rom_rd(rom_rd),
		.rom_addr(rom_addr), .rom_data(rom_data), .rf_re(rf_re),
		.rf_we(rf_we), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
		.rf_rdata(rf_rdata), .addr_high_byte(addr_high_byte),
		.mux_out(mux_out), .address_strobe_n(address_strobe_n),
		.data_strobe_n(data_strobe_n), .read_write_n(read_write_n),
		.mux_in(mux_in));

	// Second unit without external ports and with ROM protection on
	mms_core #(.HAS_EXT_PORTS(1'b0), .ROM_PROTECT(1'b1)) dut_prot (
		.core_clk(core_clk), .nrst(nrst), .cmd_valid(p_valid),
		.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready(p_ready), .rsp_valid(p_rsp_valid),
		.rsp_data(p_rsp_data), .rsp_blocked(p_blocked), .rsp_ptr(p_ptr),
		.pc_value(p_pc), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(),
		.port3_mode_dm(port3_mode_dm), .rom_rd(p_rom_rd),
		.rom_addr(p_rom_addr), .rom_data(p_rom_data), .rf_re(p_rf_re),
		.rf_we(p_rf_we), .rf_addr(p_rf_addr), .rf_wdata(p_rf_wdata),
		.rf_rdata(p_rf_rdata), .addr_high_byte(p_ahb),
		.mux_addr_data_low_out(p_mux_out), .mux_addr_data_low_oe(),
		.mux_addr_data_low_in(p_mux_in), .address_strobe_n(p_as),
		.data_strobe_n(p_ds), .read_write_n(p_rw), .port3_bit4());

	mms_mem_model mem_p (.core_clk(core_clk), .rom_rd(p_rom_rd),
		.rom_addr(p_rom_addr), .rom_data(p_rom_data), .rf_re(p_rf_re),
		.rf_we(p_rf_we), .rf_addr(p_rf_addr), .rf_wdata(p_rf_wdata),
		.rf_rdata(p_rf_rdata), .addr_high_byte(p_ahb),
		.mux_out(p_mux_out), .address_strobe_n(p_as),
		.data_strobe_n(p_ds), .read_write_n(p_rw), .mux_in(p_mux_in));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Address and data phase capture of every external cycle
	always @(posedge core_clk) begin
		if (!address_strobe_n) begin
			seen_dm <= port3_bit4;
			seen_addr <= {addr_high_byte, mux_out};
		end
		if (!data_strobe_n) begin
			seen_oe <= mux_oe;
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic close_out();
		if (fail_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wait_for(input logic rsp);
		int n;
		n = 0;
		while ((rsp ? rsp_valid : cmd_ready) !== 1'b1) begin
			@(posedge core_clk);
			#1;
			n++;
			if (n > 300) begin
				fail_count++;
				close_out();
			end
		end
	endtask : wait_for

	task automatic run(input mms_pkg::mms_op_t op, input logic [15:0] a,
		input logic [7:0] d);
		wait_for(1'b0);
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		#1;
		wait_for(1'b1);
		@(posedge core_clk);
		#1;
	endtask : run

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wreg

	task automatic creg(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		@(posedge core_clk);
		reg_addr <= a;
		repeat (2) @(posedge core_clk);
		#1;
		check(what, {8'h00, reg_rdata}, {8'h00, exp});
	endtask : creg

	task automatic fetch(input logic [15:0] a);
		run(mms_pkg::OP_JUMP, a, 8'h00);
		run(mms_pkg::OP_FETCH, 16'h0000, 8'h00);
		mpc = a + 16'h0001;
		check("pc", pc_value, mpc);
	endtask : fetch

	// One command to the protected unit, with bounded waits
	task automatic prun(input mms_pkg::mms_op_t op, input logic [15:0] a);
		int n;
		n = 0;
		while (p_ready !== 1'b1 && n < 300) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		@(posedge core_clk);
		p_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		@(posedge core_clk);
		p_valid <= 1'b0;
		#1;
		while (p_rsp_valid !== 1'b1 && n < 300) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 300) begin
			fail_count++;
			close_out();
		end
		@(posedge core_clk);
		#1;
	endtask : prun

	initial begin
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = mms_pkg::OP_FETCH;
		cmd_addr = 16'h0000;
		cmd_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		port3_mode_dm = 2'h0;
		p_valid = 1'b0;
		fail_count = 0;
		check_count = 0;
		repeat (12) @(posedge core_clk);
		#1;
		check("pc reset", pc_value, 16'h000c);
		@(posedge core_clk);
		nrst <= 1'b1;
		creg("mode", 8'hf8, 8'h04);
		creg("sp high", 8'hfe, 8'h00);
		creg("sp low", 8'hff, 8'h00);
		creg("unmapped", 8'h10, 8'h00);
		run(mms_pkg::OP_FETCH, 16'h0000, 8'h00);
		check("first op", {8'h00, rsp_data}, 16'h00a9);
		fetch(16'h0004);
		check("vector byte", {8'h00, rsp_data}, 16'h00a1);
		fetch(16'h0fff);
		check("rom top", {8'h00, rsp_data}, 16'h005a);
		fetch(16'h1000);
		check("ext op", {8'h00, rsp_data}, 16'h002c);
		check("ext addr", seen_addr, 16'h1000);
		check("ext dm", {15'h0, seen_dm}, 16'h0001);
		fetch(16'hffff);
		check("ext last", {8'h00, rsp_data}, 16'h003c);
		@(posedge core_clk);
		port3_mode_dm <= mms_pkg::DM_EN_BITS;
		for (int i = 0; i < 4; i++) begin
			run(lops[i], 16'h2345, 8'h00);
			check("load", {8'h00, rsp_data}, 16'h005a);
			check("load dm", {15'h0, seen_dm}, {15'h0, ~i[1]});
			check("load ptr", rsp_ptr, 16'h2345 + i[0]);
			check("blocked", {15'h0, rsp_blocked}, 16'h0000);
			check("load oe", {15'h0, seen_oe}, 16'h0000);
		end
		wreg(8'hf8, 8'h00);
		wreg(8'hfe, 8'h30);
		wreg(8'hff, 8'h00);
		sp = 16'h3000;
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			run(mms_pkg::OP_PUSH, 16'h0000, seed[7:0]);
			sp--;
			stk.push_back(seed[7:0]);
			check("push addr", seen_addr, sp);
			check("push oe", {15'h0, seen_oe}, 16'h0001);
		end
		creg("sp high", 8'hfe, sp[15:8]);
		creg("sp low", 8'hff, sp[7:0]);
		for (int i = 0; i < 4; i++) begin
			run(mms_pkg::OP_POP, 16'h0000, 8'h00);
			check("pop", {8'h00, rsp_data}, {8'h00, stk.pop_back()});
		end
		run(mms_pkg::OP_CALL, 16'h0200, 8'h00);
		check("call pc", pc_value, 16'h0200);
		run(mms_pkg::OP_RET, 16'h0000, 8'h00);
		check("ret pc", pc_value, mpc);
		seed = xs(seed);
		flags = seed[7:0];
		run(mms_pkg::OP_INT, 16'h0006, flags);
		run(mms_pkg::OP_INTERRUPT_RETURN, 16'h0000, 8'h00);
		check("interrupt_return flags", {8'h00, rsp_data}, {8'h00, flags});
		check("interrupt_return pc", pc_value, mpc);
		creg("sp low", 8'hff, 8'h00);
		wreg(8'hf8, 8'h04);
		wreg(8'hfe, 8'h55);
		wreg(8'hff, 8'h80);
		seed = xs(seed);
		run(mms_pkg::OP_PUSH, 16'h0000, seed[7:0]);
		creg("int sp", 8'hff, 8'h7f);
		creg("int sph", 8'hfe, 8'h55);
		run(mms_pkg::OP_POP, 16'h0000, 8'h00);
		check("int pop", {8'h00, rsp_data}, {8'h00, seed[7:0]});
		wreg(8'hff, 8'h00);
		run(mms_pkg::OP_PUSH, 16'h0000, 8'h77);
		creg("wrap sp", 8'hff, 8'hff);
		creg("wrap sph", 8'hfe, 8'h55);
		run(mms_pkg::OP_POP, 16'h0000, 8'h00);
		check("ctrl pop", {8'h00, rsp_data}, 16'h0000);
		creg("wrap back", 8'hff, 8'h00);
		prun(mms_pkg::OP_JUMP, 16'h1000);
		prun(mms_pkg::OP_FETCH, 16'h0000);
		check("nop op", {8'h00, p_rsp_data}, 16'h00ff);
		check("nop pc", p_pc, 16'h1001);
		prun(mms_pkg::OP_JUMP, 16'hffff);
		prun(mms_pkg::OP_FETCH, 16'h0000);
		check("nop wrap", p_pc, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			prun(lops[i], 16'h0100);
			check("prot data", {8'h00, p_rsp_data}, 16'h0000);
			check("prot ptr", p_ptr, 16'h0100);
			check("prot blk", {15'h0, p_blocked}, 16'h0001);
		end
		close_out();
	end
endmodule : test_memory_map_and_stack
